// ### shared/instr_subset_pkg.sv
// Package with opcodes, widths and reset values for the instruction subset unit.
package instr_subset_pkg;
   localparam int DATA_W = 4;
   localparam int OP_W = 10;
   localparam int ADDR_W = 6;
   // Opcodes are decoded elsewhere; these codes select the operation here.
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_OR_MEM = 3'h1;
   localparam logic [2:0] OP_ENTER_BACKUP = 3'h2;
   localparam logic [2:0] OP_BACKUP_ENABLE = 3'h3;
   localparam logic [2:0] OP_ROTATE_RIGHT = 3'h4;
   localparam logic [2:0] OP_CLEAR_BIT = 3'h5;
   localparam logic [2:0] OP_NO_OPERATION = 3'h6;
   localparam logic [DATA_W-1:0] ACC_RESET = 4'h0;
   localparam logic CARRY_RESET = 1'b0;
   localparam logic [1:0] BIT_SEL_LSB = 2'h0;
endpackage

// ### hdl/bit_clear_unit.sv
// Combinational unit that clears one selected bit of a memory word.
`timescale 1ns/100ps
`default_nettype none
module bit_clear_unit
   import instr_subset_pkg::*;
(
   input  wire logic [DATA_W-1:0] word_in,
   input  wire logic [1:0]        bit_sel,
   output logic      [DATA_W-1:0] word_out
);
   genvar g;
   generate
      for (g = 0; g < DATA_W; g++)
      begin : g_bit
         assign word_out[g] = (bit_sel == 2'(g)) ? 1'b0 : word_in[g];
      end
   endgenerate
endmodule
`default_nettype wire

// ### hdl/cpu_instruction_subset.sv
// Execution unit for OR, back-up entry, rotate right through carry and bit clear.
`timescale 1ns/100ps
`default_nettype none
module cpu_instruction_subset
   import instr_subset_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              instr_valid,
   input  wire logic [2:0]        instr_op,
   input  wire logic [1:0]        bit_sel,
   input  wire logic [DATA_W-1:0] mem_rdata,
   input  wire logic              wake,
   output logic      [DATA_W-1:0] mem_wdata,
   output logic                   mem_we,
   output logic      [DATA_W-1:0] acc,
   output logic                   carry_flag,
   output logic                   backup_mode
);
   // Core run state; with two states a single bit is already a Gray sequence.
   typedef enum logic
   {
      STATE_RUN    = 1'b0,
      STATE_BACKUP = 1'b1
   } core_state_t;

   // Instruction strobes; nothing executes while the system sits in back-up state.
   logic              executing;
   logic              do_enter;
   logic              do_enable;
   logic              do_clear;
   logic              entry_armed;
   logic              in_backup;

   // Architectural state and registered memory write port.
   core_state_t       state_q;
   logic [DATA_W-1:0] acc_q;
   logic              carry_q;
   logic              enable_seen_q;
   logic [DATA_W-1:0] mem_wdata_q;
   logic              mem_we_q;

   // Operation results, formed beside the registers that take them.
   logic [DATA_W-1:0] or_word;
   logic [DATA_W-1:0] rotated_acc;
   logic              rotated_carry;
   logic [DATA_W-1:0] cleared_word;

   bit_clear_unit u_clear (
      .word_in  (mem_rdata),
      .bit_sel  (bit_sel),
      .word_out (cleared_word)
   );

   assign in_backup = (state_q == STATE_BACKUP);
   assign executing = instr_valid && !in_backup;
   assign do_enter  = executing && (instr_op == OP_ENTER_BACKUP);
   assign do_enable = executing && (instr_op == OP_BACKUP_ENABLE);
   assign do_clear  = executing && (instr_op == OP_CLEAR_BIT);

   // An entry instruction without the enabling one just before it is a no-op.
   assign entry_armed = do_enter && enable_seen_q;

   assign or_word = acc_q | mem_rdata;

   // The accumulator and the carry form a five-bit ring that turns one place right.
   // The old carry enters the top bit and bit 0 falls out into the carry.
   genvar r;
   generate
      for (r = 0; r < DATA_W; r++)
      begin : g_rotate
         if (r == DATA_W - 1)
         begin : g_top
            assign rotated_acc[r] = carry_q;
         end
         else
         begin : g_low
            assign rotated_acc[r] = acc_q[r + 1];
         end
      end
   endgenerate
   assign rotated_carry = acc_q[0];

   // Accumulator: only OR and rotate write it; every other code leaves it as it is.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         acc_q <= ACC_RESET;
      end
      else if (executing)
      begin
         case (instr_op)
            OP_OR_MEM:
            begin
               acc_q <= or_word;
            end
            OP_ROTATE_RIGHT:
            begin
               acc_q <= rotated_acc;
            end
            OP_ENTER_BACKUP, OP_BACKUP_ENABLE, OP_NO_OPERATION:
            begin
               acc_q <= acc_q;
            end
            default:
            begin
               acc_q <= acc_q;
            end
         endcase
      end
   end

   // Carry: moved only by the rotate; OR, entry and bit clear leave it unchanged.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         carry_q <= CARRY_RESET;
      end
      else if (executing)
      begin
         case (instr_op)
            OP_ROTATE_RIGHT:
            begin
               carry_q <= rotated_carry;
            end
            OP_OR_MEM, OP_ENTER_BACKUP, OP_CLEAR_BIT:
            begin
               carry_q <= carry_q;
            end
            default:
            begin
               carry_q <= carry_q;
            end
         endcase
      end
   end

   // Arming for back-up entry: set by the enabling instruction, dropped by any
   // other executed one; cycles without an instruction keep it.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         enable_seen_q <= 1'b0;
      end
      else if (executing)
      begin
         enable_seen_q <= do_enable;
      end
   end

   // Back-up state: entered by an armed entry instruction, left only by wake.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= STATE_RUN;
      end
      else
      begin
         case (state_q)
            STATE_RUN:
            begin
               if (entry_armed)
               begin
                  state_q <= STATE_BACKUP;
               end
            end
            STATE_BACKUP:
            begin
               if (wake)
               begin
                  state_q <= STATE_RUN;
               end
            end
            default:
            begin
               state_q <= STATE_RUN;
            end
         endcase
      end
   end

   // Write strobe: a one-cycle pulse in the cycle after a bit clear instruction.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mem_we_q <= 1'b0;
      end
      else
      begin
         mem_we_q <= do_clear;
      end
   end

   // Write data: the addressed word with the selected bit cleared, held until the next clear.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mem_wdata_q <= ACC_RESET;
      end
      else if (do_clear)
      begin
         mem_wdata_q <= cleared_word;
      end
   end

   // Outputs come straight from the registers so the core sees no decode glitches.
   assign acc         = acc_q;
   assign carry_flag  = carry_q;
   assign backup_mode = in_backup;
   assign mem_wdata   = mem_wdata_q;
   assign mem_we      = mem_we_q;
endmodule
`default_nettype wire

// ### verification/cpu_instruction_subset_assertions.sv
// Concurrent checks on the ports of the instruction subset unit.
`timescale 1ns/100ps
`default_nettype none
module cpu_instruction_subset_checker
   import instr_subset_pkg::*;
(
   input wire logic              clk,
   input wire logic              reset_n,
   input wire logic              instr_valid,
   input wire logic              wake,
   input wire logic              mem_we,
   input wire logic              carry_flag,
   input wire logic              backup_mode,
   input wire logic [2:0]        instr_op,
   input wire logic [1:0]        bit_sel,
   input wire logic [DATA_W-1:0] mem_rdata,
   input wire logic [DATA_W-1:0] mem_wdata,
   input wire logic [DATA_W-1:0] acc
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire logic v = instr_valid && !backup_mode;
   chk_or_accum:
      assert property (v && instr_op == OP_OR_MEM |=> acc == $past(acc | mem_rdata) && $stable(carry_flag)) else $error("or");
   chk_backup_entry:
      assert property ((v && instr_op == OP_BACKUP_ENABLE) ##1 (v && instr_op == OP_ENTER_BACKUP) |=> backup_mode)
      else $error("entry");
   chk_entry_gated:
      assert property (v && instr_op == OP_ENTER_BACKUP && $past(v && instr_op != OP_BACKUP_ENABLE)
         |=> !backup_mode && $stable(acc)) else $error("gate");
   chk_rotate_ring:
      assert property (v && instr_op == OP_ROTATE_RIGHT |=> {acc, carry_flag} == {$past(carry_flag), $past(acc)})
      else $error("ring");
   chk_rotate_carry:
      assert property (v && instr_op == OP_ROTATE_RIGHT && acc[0] != carry_flag
         |=> carry_flag != $past(carry_flag) && acc[3] == $past(carry_flag)) else $error("carry");
   chk_clear_bit:
      assert property (v && instr_op == OP_CLEAR_BIT
         |=> mem_we && mem_wdata == ($past(mem_rdata) & ~(4'h1 << $past(bit_sel)))) else $error("clear");
   chk_backup_hold:
      assert property (backup_mode && !wake |=> backup_mode && $stable(acc) && $stable(carry_flag) && !mem_we)
      else $error("hold");
   chk_backup_wake:
      assert property (backup_mode && wake |=> !backup_mode) else $error("wake");
endmodule
bind cpu_instruction_subset cpu_instruction_subset_checker u_chk (.clk, .reset_n, .instr_valid, .wake, .mem_we,
   .carry_flag, .backup_mode, .instr_op, .bit_sel, .mem_rdata, .mem_wdata, .acc);
`default_nettype wire

// ### verification/testbench.sv
// Random self-checking testbench with a reference model of the unit.
`timescale 1ns/100ps
`default_nettype none
module testbench
   import instr_subset_pkg::*;
;
   logic       clk = 0, reset_n = 0, instr_valid = 0, wake = 0, mem_we, carry_flag, backup_mode;
   logic       e_carry, e_bk, e_en, e_we;
   logic [2:0] instr_op = '0;
   logic [1:0] bit_sel = '0;
   logic [3:0] mem_rdata = '0, mem_wdata, acc, e_acc, e_wd;
   logic [15:0] lfsr = 16'hb390;
   int         mismatches = 0, cmp_count = 0, cyc = 0;
   cpu_instruction_subset u_dut (.clk, .reset_n, .instr_valid, .instr_op, .bit_sel, .mem_rdata, .wake,
      .mem_wdata, .mem_we, .acc, .carry_flag, .backup_mode);
   always #5 clk = ~clk;
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Expected word after clearing bit j: the whole word copied, then bit j set to zero.
   function automatic logic [3:0] clr_exp(input logic [3:0] w, input logic [1:0] j);
      logic [3:0] r;
      r = w;
      r[j] = 1'b0;
      return r;
   endfunction
   // Every 40 cycles an enable is forced, then an entry in the next cycle unless lfsr[2:0] is 7 there, which gives another enable.
   always @(posedge clk) if (!reset_n)
   begin
      instr_valid <= 1'b0;
   end
   else
   begin
      lfsr <= nxt(lfsr);
      cyc <= cyc + 1;
      instr_valid <= lfsr[12] | lfsr[11] | (cyc % 40 < 2);
      instr_op <= (cyc % 40 == 0 || lfsr[2:0] == 3'h7) ? OP_BACKUP_ENABLE : (cyc % 40 == 1) ? OP_ENTER_BACKUP : lfsr[2:0];
      {bit_sel, mem_rdata, wake} <= {lfsr[9:4], lfsr[15] & lfsr[14]};
   end
   always @(posedge clk or negedge reset_n)
      if (!reset_n) {e_acc, e_carry, e_bk, e_en, e_we} <= {ACC_RESET, CARRY_RESET, 3'h0};
      else
      begin
         e_we <= 1'b0;
         if (e_bk) e_bk <= !wake;
         else if (instr_valid)
         begin
            e_en <= instr_op == OP_BACKUP_ENABLE;
            if (instr_op == OP_OR_MEM) e_acc <= e_acc | mem_rdata;
            if (instr_op == OP_ENTER_BACKUP) e_bk <= e_en;
            if (instr_op == OP_ROTATE_RIGHT) {e_acc, e_carry} <= {e_carry, e_acc};
            if (instr_op == OP_CLEAR_BIT) {e_we, e_wd} <= {1'b1, clr_exp(mem_rdata, bit_sel)};
         end
      end
   task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
      cmp_count++;
      if (e !== s)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   always @(negedge clk)
   begin
      chk("acc", e_acc, acc);
      chk("carry", {3'h0, e_carry}, {3'h0, carry_flag});
      chk("backup", {3'h0, e_bk}, {3'h0, backup_mode});
      chk("we", {3'h0, e_we}, {3'h0, mem_we});
      if (e_we) chk("wdata", e_wd, mem_wdata);
   end
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (1500) @(posedge clk);
      // A second reset in mid-run checks that acc, carry_flag, backup_mode and mem_we return to their reset values.
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (1500) @(posedge clk);
      finish_test();
   end
   initial
   begin
      #100000;
      mismatches++;
      finish_test();
   end
endmodule
`default_nettype wire
